/* tb/ptpc_conv_properties.sv */
// Port-level assertions for the converter
module ptpc_conv_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic mic_bit_clock,
  input wire logic [23:0] pcm_left,
  input wire logic [23:0] pcm_right,
  input wire logic pcm_valid,
  input wire ptpc_pkg::ptpc_clk_src_t module_clock_select,
  input wire logic xtal32k_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  import ptpc_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] hi_cnt;
  // Length of the current high phase of the bit clock
  always_ff @(posedge aclk) begin
    if (!aresetn || !mic_bit_clock) hi_cnt <= 8'h00;
    else if (hi_cnt != 8'hFF) hi_cnt <= hi_cnt + 8'h01;
  end
  // ****************
  // Properties
  // ****************
  a_aw_blocked: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  a_ar_blocked: assert property (rvalid |-> !arready)
    else $error("read taken while data pending");
  a_b_latency: assert property (awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
    else $error("write response late or early");
  a_r_latency: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_valid_pulse: assert property (pcm_valid |=> !pcm_valid)
    else $error("sample strobe too long");
  a_pcm_hold: assert property (pcm_valid |=> ($stable(pcm_left) && $stable(pcm_right)) [*8])
    else $error("sample changed after strobe");
  a_xtal_follow: assert property (xtal32k_enable == (module_clock_select == SRC_HS_CRYSTAL))
    else $error("slow crystal enable wrong");
  a_bclk_high: assert property (hi_cnt <= 8'h20)
    else $error("bit clock high too long");
  a_reset_idle: assert property (disable iff (1'b0)
      !aresetn |=> !bvalid && !rvalid && !pcm_valid && !mic_bit_clock)
    else $error("outputs busy after reset");
endmodule // ptpc_conv_chk

/* tb/ptpc_conv_tb.sv */
// Self-checking bench for the converter
`include "ptpc_defines.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module ptpc_conv_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ptpc_pkg::*;
  logic aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready, arvalid;
  logic arready, rvalid, rready, pdm_data, mic_bit_clock, pcm_valid, xtal32k_enable, lbit, rbit;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, q;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [23:0] pcm_left, pcm_right;
  ptpc_clk_src_t module_clock_select;
  int n_tests, n_fail;
  ptpc_conv ptpc_conv_inst (.*);
  ptpc_mic ptpc_mic_inst (.aclk(aclk), .mic_bit_clock(mic_bit_clock), .left_bit(lbit),
    .right_bit(rbit), .pdm_data(pdm_data));
  // ****************
  // Tasks
  // ****************
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic xfer(input bit w, input logic [7:0] a, input logic [31:0] d);
    int k;
    logic ha, hw, hr, dn;
    if (w) begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    for (k = 0; k < 64; k++) begin
      @(negedge aclk);
      ha = awready;
      hw = wready;
      hr = arready;
      dn = w ? bvalid : rvalid;
      q = rdata;
      r = w ? bresp : rresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hr) arvalid <= 1'b0;
      if (dn) break;
    end
    bready <= 1'b0;
    rready <= 1'b0;
    if (k == 64) begin
      n_fail++;
      final_report();
    end
    @(posedge aclk);
  endtask
  task automatic wait_valid(output int c);
    c = 0;
    do begin
      @(negedge aclk);
      c++;
    end while (pcm_valid !== 1'b1 && c < 5000);
    if (c == 5000) begin
      n_fail++;
      final_report();
    end
  endtask
  function automatic logic [23:0] exp_pcm(input bit b, input int dec, input int g);
    longint v;
    v = (b ? 64'sh1_0000 : -64'sh1_0000) * dec;
    v = g >= 8 ? v <<< ((g - 8) / 4) : v >>> ((8 - g) / 4);
    if (v > 64'sh7F_FFFF) v = 64'sh7F_FFFF;
    if (v < -64'sh80_0000) v = -64'sh80_0000;
    return v[23:0];
  endfunction
  task automatic run(input int sw, ch, cd, md, dec, gl, gr, input bit lb, rb);
    int c;
    lbit <= lb;
    rbit <= rb;
    // Stop first so no frame spans two settings
    xfer(1'b1, `PTPC_CTRL_OFF, 32'h0000_0000);
    xfer(1'b1, `PTPC_DIV_OFF, 32'(cd | md << 4 | dec << 8));
    xfer(1'b1, `PTPC_GAIN_OFF, 32'(gl | gr << 8));
    xfer(1'b1, `PTPC_CTRL_OFF, 32'(1 | sw << 1 | ch << 2 | ($urandom % 8) << 4));
    wait_valid(c);
    wait_valid(c);
    wait_valid(c);
    `CHK(c, 2 * dec * (md + 1) * (cd + 1))
    `CHK(pcm_left, exp_pcm(sw ? rb : lb, dec, gl))
    `CHK(pcm_right, ch == 1 ? 24'h00_0000 : exp_pcm(sw ? lb : rb, dec, gr))
    $display("test sw%0d ch%0d md%0d dec%0d done", sw, ch, md, dec);
    repeat (10) @(posedge aclk);
  endtask
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, lbit, rbit} = 8'h00;
    {awaddr, araddr, wdata} = 48'h0;
    ce = 1'b1;
    wstrb = 4'hF;
    n_tests = 0;
    n_fail = 0;
    void'($urandom(96081));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    xfer(1'b0, `PTPC_CTRL_OFF, 32'h0);
    `CHK(q, `PTPC_CTRL_RST)
    xfer(1'b0, `PTPC_DIV_OFF, 32'h0);
    `CHK(q, 32'(1 | 3 << 4 | 96 << 8))
    xfer(1'b0, `PTPC_GAIN_OFF, 32'h0);
    `CHK(q, `PTPC_GAIN_RST)
    xfer(1'b0, 8'h20, 32'h0);
    `CHK(r, `PTPC_RESP_SLVERR)
    xfer(1'b1, `PTPC_STAT_OFF, 32'h0);
    `CHK(r, `PTPC_RESP_SLVERR)
    $display("test registers done");
    run(0, 2, 1, 3, 96, 8, 8, 1'b1, 1'b0);
    // Clock enable low freezes bit clock and samples
    ce <= 1'b0;
    @(negedge aclk);
    q = {7'h00, mic_bit_clock, pcm_left};
    repeat (16) @(negedge aclk);
    `CHK({7'h00, mic_bit_clock, pcm_left}, q)
    @(posedge aclk);
    ce <= 1'b1;
    $display("test clock enable done");
    run(1, 3, 1, 3, 96, 12, 4, 1'b1, 1'b0);
    run(0, 1, 1, 3, 32, 8, 8, 1'b0, 1'b1);
    run(1, 1, 2, 7, 16, 28, 0, 1'b1, 1'b0);
    repeat (5) run($urandom % 2, 1 + $urandom % 3, 1 + $urandom % 3, 3 + 2 * ($urandom % 2),
      16 + $urandom % 49, 4 * ($urandom % 8), 4 * ($urandom % 8), 1'($urandom), 1'($urandom));
    xfer(1'b1, `PTPC_CTRL_OFF, 32'h0000_0200);
    repeat (50) @(posedge aclk);
    @(negedge aclk);
    `CHK(xtal32k_enable, 1'b1)
    `CHK(module_clock_select, SRC_HS_CRYSTAL)
    `CHK(mic_bit_clock, 1'b0)
    `CHK(pcm_left, 24'h00_0000)
    @(posedge aclk);
    xfer(1'b1, `PTPC_CTRL_OFF, 32'h0000_0000);
    @(negedge aclk);
    `CHK(xtal32k_enable, 1'b0)
    `CHK(module_clock_select, SRC_PRIMARY_RC)
    $display("test clock select done");
    final_report();
  end
endmodule // ptpc_conv_tb
bind ptpc_conv ptpc_conv_chk ptpc_conv_chk_inst (.*);

/* tb/ptpc_mic.sv */
// Stereo microphone pair sharing one data line
module ptpc_mic (
  input wire logic aclk,
  input wire logic mic_bit_clock,
  input wire logic left_bit,
  input wire logic right_bit,
  output logic pdm_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last = 1'b0;
  logic [5:0] idle = 6'h00;
  initial pdm_data = 1'b0;
  // Cycles since the bit clock last moved
  always @(posedge aclk) begin
    last <= mic_bit_clock;
    if (mic_bit_clock != last) idle <= 6'h00;
    else if (idle != 6'h3F) idle <= idle + 6'h01;
  end
  // Left drives in low phase, right in high; stopped clock makes the line toggle every cycle
  always @(posedge aclk) begin
    if (idle == 6'h3F) pdm_data <= ~pdm_data;
    else pdm_data <= mic_bit_clock ? right_bit : left_bit;
  end
endmodule // ptpc_mic

/* verilog/ptpc_conv.sv */
// PDM-to-PCM converter with AXI4-Lite register slave
// Contract
// [RL1] Convert one-bit PDM streams to 24-bit PCM
// [RL2] Rising-edge bit is left, falling is right
// [RL3] Swap option exchanges edge-to-channel assignment
// [RL4] Mono: only left valid, right held zero
// [RL5] Reset configuration yields 16 kHz output
// [RL6] Support 8 to 192 kHz output rates
// [RL7] Bit clock configurable 512 kHz to 3.072 MHz
// [RL8] Gain -12 to +34.5 dB, 1.5 dB steps
// [RL9] Core clock = master / (divider + 1)
// [RL10] Left and right core clocks equal core
// [RL11] Bit clock = left core / (mic divider + 1)
// [RL12] Oversampling ratio is twice decimation field
// [RL13] Software keeps decimation at 16-64 or 96
// [RL14] Bit and filter clocks derived internally
// [RL15] Programmable delay shifts bit clock phase
// [RL16] Software orders clock source change steps
// [RL17] Software switches away before clearing force bit
// [RL18] High-speed crystal selection enables 32 kHz crystal
// [RL19] Software uses recommended divider combinations
// [RL20] Mono: software sets swap per microphone side
// [RL21] Left core always runs, right gated by set; the left core here runs only while enabled and set is not CHSET_OFF
// [RL22] Present PCM pair with valid per frame
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`include "ptpc_defines.svh"

module ptpc_conv (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic awvalid,
  output logic awready,
  input wire logic [`PTPC_ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [`PTPC_ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic pdm_data,
  output logic mic_bit_clock,
  output logic [23:0] pcm_left,
  output logic [23:0] pcm_right,
  output logic pcm_valid,
  output ptpc_pkg::ptpc_clk_src_t module_clock_select,
  output logic xtal32k_enable
);
  import ptpc_pkg::*;

  // ************************************************************
  // Registers and decoded fields
  // ************************************************************
  logic [31:0] ctrl_reg;
  logic [31:0] div_reg;
  logic [31:0] gain_reg;
  logic enable;
  logic swap;
  ptpc_chset_t chset;
  logic [2:0] dly;
  logic [1:0] core_clock_divider_value;
  logic [3:0] mic_clock_divider;
  logic [6:0] decimation_rate_field;
  logic [7:0] oversampling_ratio;
  logic left_on;
  logic right_on;
  assign enable = ctrl_reg[`PTPC_EN_BIT];
  assign swap = ctrl_reg[`PTPC_SWAP_BIT];
  assign chset = ptpc_chset_t'(ctrl_reg[`PTPC_CHSET_LSB +: 2]);
  assign dly = ctrl_reg[`PTPC_DLY_LSB +: 3];
  assign module_clock_select = ptpc_clk_src_t'(ctrl_reg[`PTPC_MODULE_CLOCK_SELECT_LSB +: 2]);
  assign xtal32k_enable = (module_clock_select == SRC_HS_CRYSTAL); // RL18
  assign core_clock_divider_value = div_reg[`PTPC_CDIV_LSB +: 2];
  assign mic_clock_divider = div_reg[`PTPC_MDIV_LSB +: 4];
  assign decimation_rate_field = div_reg[`PTPC_SINC_LSB +: 7];
  assign oversampling_ratio = {decimation_rate_field, 1'b0}; // RL12
  assign left_on = enable && (chset != CHSET_OFF); // RL21
  assign right_on = enable && (chset == CHSET_STEREO || chset == CHSET_STEREO_ALT); // RL21
  // ************************************************************
  // AXI4-Lite write path
  // ************************************************************
  logic aw_got;
  logic w_got;
  logic [`PTPC_ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_do;
  logic wr_hit;
  assign awready = !aw_got && !bvalid;
  assign wready = !w_got && !bvalid;
  assign wr_do = aw_got && w_got;
  assign wr_hit = (aw_addr_q == `PTPC_CTRL_OFF) || (aw_addr_q == `PTPC_DIV_OFF) ||
                  (aw_addr_q == `PTPC_GAIN_OFF);
  logic [31:0] wmask;
  assign wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_got <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_got <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_do) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `PTPC_RESP_OKAY;
    end else if (ce) begin
      if (wr_do) begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? `PTPC_RESP_OKAY : `PTPC_RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end
  // Reset values give 3.072 MHz bit clock and 16 kHz output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `PTPC_CTRL_RST; // RL5
      div_reg <= `PTPC_DIV_RST; // RL5
      gain_reg <= `PTPC_GAIN_RST;
    end else if (ce && wr_do) begin
      case (aw_addr_q)
        `PTPC_CTRL_OFF: ctrl_reg <= ((ctrl_reg & ~wmask) | (w_data_q & wmask)) & 32'h0000_037F;
        `PTPC_DIV_OFF: div_reg <= ((div_reg & ~wmask) | (w_data_q & wmask)) & 32'h0000_7FF3;
        `PTPC_GAIN_OFF: gain_reg <= ((gain_reg & ~wmask) | (w_data_q & wmask)) & 32'h0000_1F1F;
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // ************************************************************
  // AXI4-Lite read path
  // ************************************************************
  logic [31:0] rd_mux;
  logic rd_hit;
  logic ck_reg;
  assign arready = !rvalid;
  always_comb begin
    rd_hit = 1'b1;
    case (araddr)
      `PTPC_CTRL_OFF: rd_mux = ctrl_reg;
      `PTPC_DIV_OFF: rd_mux = div_reg;
      `PTPC_GAIN_OFF: rd_mux = gain_reg;
      `PTPC_LEFT_OFF: rd_mux = {8'h00, pcm_left};
      `PTPC_RIGHT_OFF: rd_mux = {8'h00, pcm_right};
      `PTPC_STAT_OFF: rd_mux = {29'h0, ck_reg, right_on, left_on};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= `PTPC_RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata <= rd_mux;
        rresp <= rd_hit ? `PTPC_RESP_OKAY : `PTPC_RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Clock dividers: core tick and microphone bit clock
  // ************************************************************
  logic [1:0] cdiv_cnt;
  logic core_tick;
  logic [3:0] mdiv_cnt;
  logic [4:0] half;
  logic rise_ev;
  logic fall_ev;
  // Both channel cores share this tick
  assign core_tick = left_on && (cdiv_cnt == core_clock_divider_value); // RL9 RL10 RL14
  assign half = 5'((5'(mic_clock_divider) + 5'd1) >> 1);
  assign rise_ev = core_tick && (mdiv_cnt == mic_clock_divider); // RL11
  assign fall_ev = core_tick && (5'(mdiv_cnt) + 5'd1 == half); // RL11 RL7
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cdiv_cnt <= '0;
    end else if (ce) begin
      if (!left_on || core_tick) begin
        cdiv_cnt <= '0;
      end else begin
        cdiv_cnt <= cdiv_cnt + 2'd1; // RL9
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mdiv_cnt <= '0;
      ck_reg <= 1'b0;
    end else if (ce) begin
      if (!left_on) begin
        mdiv_cnt <= '0;
        ck_reg <= 1'b0;
      end else if (core_tick) begin
        mdiv_cnt <= rise_ev ? 4'd0 : mdiv_cnt + 4'd1;
        if (rise_ev) begin
          ck_reg <= 1'b1;
        end else if (fall_ev) begin
          ck_reg <= 1'b0;
        end
      end
    end
  end

  // ************************************************************
  // Phase delay line for bit clock and capture strobes
  // ************************************************************
  logic [6:0] dl_ck;
  logic [6:0] dl_rise;
  logic [6:0] dl_fall;
  logic [7:0] tap_ck;
  logic [7:0] tap_rise;
  logic [7:0] tap_fall;
  logic rise_q;
  logic fall_q;
  assign tap_ck = {dl_ck, ck_reg};
  assign tap_rise = {dl_rise, rise_ev};
  assign tap_fall = {dl_fall, fall_ev};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dl_ck <= '0;
      dl_rise <= '0;
      dl_fall <= '0;
      mic_bit_clock <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else if (ce) begin
      dl_ck <= tap_ck[6:0];
      dl_rise <= tap_rise[6:0];
      dl_fall <= tap_fall[6:0];
      mic_bit_clock <= tap_ck[dly]; // RL15 RL14
      rise_q <= tap_rise[dly]; // RL15
      fall_q <= tap_fall[dly]; // RL15
    end
  end

  // ************************************************************
  // Data pin synchroniser
  // ************************************************************
  logic pdm_meta;
  logic pdm_s;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pdm_meta <= 1'b0;
      pdm_s <= 1'b0;
    end else if (ce) begin
      pdm_meta <= pdm_data;
      pdm_s <= pdm_meta;
    end
  end

  // ************************************************************
  // Frame counter and per-channel decimation with gain
  // ************************************************************
  logic [7:0] bit_cnt;
  logic frame_end;
  logic ev [2];
  logic on [2];
  logic [4:0] gcode [2];
  logic [23:0] pcm_q [2];
  assign frame_end = rise_q && (bit_cnt == oversampling_ratio - 8'd1); // RL12 RL6
  assign ev[0] = swap ? fall_q : rise_q; // RL2 RL3
  assign ev[1] = swap ? rise_q : fall_q; // RL2 RL3
  assign on[0] = left_on;
  assign on[1] = right_on;
  assign gcode[0] = gain_reg[`PTPC_GL_LSB +: 5];
  assign gcode[1] = gain_reg[`PTPC_GR_LSB +: 5];
  assign pcm_left = pcm_q[0];
  assign pcm_right = pcm_q[1];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_cnt <= '0;
    end else if (ce) begin
      if (!left_on || frame_end) begin
        bit_cnt <= '0;
      end else if (rise_q) begin
        bit_cnt <= bit_cnt + 8'd1;
      end
    end
  end

  // Gain of 2^(code/4)/4, about 1.5 dB per step from -12 dB
  function automatic logic [23:0] apply_gain(input logic signed [8:0] s,
                                             input logic [4:0] code);
    logic signed [23:0] base;
    logic [8:0] mant;
    logic signed [41:0] wide;
    base = 24'(s) <<< `PTPC_PCM_SHIFT;
    case (code[1:0])
      2'd0: mant = `PTPC_MANT0;
      2'd1: mant = `PTPC_MANT1;
      2'd2: mant = `PTPC_MANT2;
      default: mant = `PTPC_MANT3;
    endcase
    wide = 42'(base * $signed({1'b0, mant}));
    wide = (wide <<< code[4:2]) >>> 10;
    if (wide > 42'sh7F_FFFF) begin
      return 24'h7F_FFFF;
    end else if (wide < -42'sh80_0000) begin
      return 24'h80_0000;
    end
    return wide[23:0];
  endfunction

  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic signed [8:0] acc_reg;
    logic signed [8:0] acc_next;
    // Sinc accumulation of +1/-1 per captured bit
    always_comb begin
      acc_next = acc_reg;
      if (ev[c]) begin
        acc_next = pdm_s ? acc_reg + 9'sd1 : acc_reg - 9'sd1; // RL1
      end
    end
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        acc_reg <= '0;
        pcm_q[c] <= '0;
      end else if (ce) begin
        if (!on[c]) begin
          acc_reg <= '0;
          pcm_q[c] <= '0; // RL4
        end else if (frame_end) begin
          acc_reg <= '0;
          pcm_q[c] <= apply_gain(acc_next, gcode[c]); // RL1 RL8
        end else begin
          acc_reg <= acc_next;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pcm_valid <= 1'b0;
    end else if (ce) begin
      pcm_valid <= frame_end && left_on; // RL22
    end
  end
endmodule // ptpc_conv

/* verilog/ptpc_defines.svh */
// Register map, field positions, reset values and scaling constants
`ifndef PTPC_DEFINES_SVH
`define PTPC_DEFINES_SVH
`define PTPC_ADDR_W 8
`define PTPC_CTRL_OFF 8'h00
`define PTPC_DIV_OFF 8'h04
`define PTPC_GAIN_OFF 8'h08
`define PTPC_LEFT_OFF 8'h0C
`define PTPC_RIGHT_OFF 8'h10
`define PTPC_STAT_OFF 8'h14
`define PTPC_EN_BIT 0
`define PTPC_SWAP_BIT 1
`define PTPC_CHSET_LSB 2
`define PTPC_DLY_LSB 4
`define PTPC_MODULE_CLOCK_SELECT_LSB 8
`define PTPC_CDIV_LSB 0
`define PTPC_MDIV_LSB 4
`define PTPC_SINC_LSB 8
`define PTPC_GL_LSB 0
`define PTPC_GR_LSB 8
`define PTPC_CTRL_RST 32'h0000_0108
`define PTPC_DIV_RST 32'h0000_6031
`define PTPC_GAIN_RST 32'h0000_0808
`define PTPC_MANT0 9'h100
`define PTPC_MANT1 9'h130
`define PTPC_MANT2 9'h16A
`define PTPC_MANT3 9'h1AF
`define PTPC_PCM_SHIFT 15
`define PTPC_RESP_OKAY 2'h0
`define PTPC_RESP_SLVERR 2'h2
`endif

/* verilog/ptpc_pkg.sv */
// Types shared by the converter
package ptpc_pkg;
  typedef enum logic [1:0] {
    CHSET_OFF, CHSET_MONO, CHSET_STEREO, CHSET_STEREO_ALT
  } ptpc_chset_t;
  typedef enum logic [1:0] {
    SRC_PRIMARY_RC, SRC_SECONDARY_RC, SRC_HS_CRYSTAL, SRC_RESERVED
  } ptpc_clk_src_t;
endpackage : ptpc_pkg
